// ==== drc_host_model.sv ====
// host model driving the register strobe port
`timescale 1ns/1ns
`default_nettype none
module drc_host_model (
  input wire logic clk_i,
  output var drc_pkg::drc_req_t req_o
);
  import drc_pkg::*;
  initial req_o = '0;
  task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: wr, rd: !wr, addr: a, wdata: {5'h00, d[2:0]}};
    @(posedge clk_i);
    req_o <= '0;
  endtask : access
endmodule : drc_host_model
`default_nettype wire

// ==== drc_pkg.sv ====
// shared constants and carrier types for the spreading rate configuration block
package drc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [5:0] DRC_SPREADING_RATE_CONFIG_OFFS = 6'h04;
  localparam logic [7:0] DRC_SPREADING_RATE_CONFIG_RESET = 8'h00;
  localparam int DRC_CODE_WIDTH_BIT = 2;
  localparam int DRC_RATE_MODE_BIT = 1;
  localparam int DRC_SAMPLE_RATE_BIT = 0;
  localparam int DRC_CFG_BITS = 3;

  // ----------------------------------------------------------------
  // invalid low-bit patterns
  // ----------------------------------------------------------------
  localparam logic [2:0] DRC_BAD_PATTERN_A = 3'h1;
  localparam logic [2:0] DRC_BAD_PATTERN_B = 3'h2;
  localparam logic [2:0] DRC_BAD_PATTERN_C = 3'h3;
  localparam logic [2:0] DRC_BAD_PATTERN_D = 3'h7;

  // ----------------------------------------------------------------
  // code and rate figures
  // ----------------------------------------------------------------
  localparam int DRC_FULL_CHIPS = 64;
  localparam int DRC_HALF_CHIPS = 32;
  localparam logic [6:0] DRC_CHIPS_64 = 7'h40;
  localparam logic [6:0] DRC_CHIPS_32 = 7'h20;
  localparam logic [1:0] DRC_BITS_PER_CODE_NORMAL = 2'h1;
  localparam logic [1:0] DRC_BITS_PER_CODE_DOUBLE = 2'h2;
  localparam logic [3:0] DRC_OVERSAMPLE_6X = 4'h6;
  localparam logic [3:0] DRC_OVERSAMPLE_12X = 4'hC;
  localparam logic [15:0] DRC_RAW_RATE_NORMAL_BPS = 16'h7D00;
  localparam logic [15:0] DRC_RAW_RATE_DOUBLE_BPS = 16'hF424;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } drc_req_t;

  typedef struct packed {
    logic code_width_32;
    logic double_rate;
    logic sample_12x;
    logic use_upper_half;
    logic config_invalid;
    logic [6:0] chips_per_code;
    logic [1:0] bits_per_code;
    logic [3:0] oversample;
    logic [15:0] raw_rate_bps;
  } drc_mode_t;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam drc_mode_t DRC_MODE_RESET = '{
    code_width_32: 1'b0,
    double_rate: 1'b0,
    sample_12x: 1'b0,
    use_upper_half: 1'b0,
    config_invalid: 1'b0,
    chips_per_code: DRC_CHIPS_64,
    bits_per_code: DRC_BITS_PER_CODE_NORMAL,
    oversample: DRC_OVERSAMPLE_6X,
    raw_rate_bps: DRC_RAW_RATE_NORMAL_BPS
  };

endpackage : drc_pkg

// ==== drc_rate_config.sv ====
// spreading rate configuration register and the mode it puts in force
`timescale 1ns/1ns
`default_nettype none

module drc_rate_config (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire drc_pkg::drc_req_t req_i,
  input wire logic code_half_select_i,
  input wire logic [63:0] pn_code_i,
  output logic [7:0] rdata_o,
  output logic [63:0] spread_code_o,
  output drc_pkg::drc_mode_t mode_o
);
  import drc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DRC_CFG_BITS-1:0] cfg;
    logic [7:0] rdata;
    logic [63:0] code;
    drc_mode_t mode;
  } drc_state_t;

  drc_state_t state_reg;
  drc_state_t state_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic drc_mode_t drc_decode(input logic [2:0] cfg, input logic half);
    drc_mode_t m;
    m.code_width_32 = cfg[DRC_CODE_WIDTH_BIT];
    m.double_rate = cfg[DRC_CODE_WIDTH_BIT] & cfg[DRC_RATE_MODE_BIT];
    m.sample_12x = cfg[DRC_CODE_WIDTH_BIT] & ~cfg[DRC_RATE_MODE_BIT] & cfg[DRC_SAMPLE_RATE_BIT];
    m.use_upper_half = cfg[DRC_CODE_WIDTH_BIT] & ~m.double_rate & half;
    m.config_invalid = (cfg == DRC_BAD_PATTERN_A) || (cfg == DRC_BAD_PATTERN_B) ||
                       (cfg == DRC_BAD_PATTERN_C) || (cfg == DRC_BAD_PATTERN_D);
    m.chips_per_code = m.code_width_32 ? DRC_CHIPS_32 : DRC_CHIPS_64;
    m.bits_per_code = m.double_rate ? DRC_BITS_PER_CODE_DOUBLE : DRC_BITS_PER_CODE_NORMAL;
    m.oversample = m.sample_12x ? DRC_OVERSAMPLE_12X : DRC_OVERSAMPLE_6X;
    m.raw_rate_bps = m.double_rate ? DRC_RAW_RATE_DOUBLE_BPS : DRC_RAW_RATE_NORMAL_BPS;
    return m;
  endfunction : drc_decode

  // the code actually correlated against, given the mode in force
  function automatic logic [63:0] drc_pick_code(input drc_mode_t m, input logic [63:0] pn);
    logic [63:0] c;
    c = pn;
    if (m.code_width_32 && !m.double_rate) begin
      c = {32'h0000_0000, m.use_upper_half ? pn[63:32] : pn[31:0]};
    end
    return c;
  endfunction : drc_pick_code

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // upper bits dropped
    // reserved bits are not stored, so a careless host cannot steer hidden state
    if (req_i.wr && req_i.addr == DRC_SPREADING_RATE_CONFIG_OFFS) begin
      state_next.cfg = req_i.wdata[DRC_CFG_BITS-1:0];
    end
    if (req_i.rd) begin
      if (req_i.addr == DRC_SPREADING_RATE_CONFIG_OFFS) begin
        state_next.rdata = {5'h00, state_reg.cfg};
      end else begin
        state_next.rdata = 8'h00;
      end
    end
    // invalid patterns flagged
    // an invalid pattern is still stored; the decode masks it to a defined mode
    state_next.mode = drc_decode(state_next.cfg, code_half_select_i);
    state_next.code = drc_pick_code(state_next.mode, pn_code_i);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg.cfg <= DRC_SPREADING_RATE_CONFIG_RESET[DRC_CFG_BITS-1:0];
      state_reg.rdata <= 8'h00;
      state_reg.code <= 64'h0000_0000_0000_0000;
      // the decode of the cleared register, so no cycle shows a zero rate
      state_reg.mode <= DRC_MODE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o = state_reg.rdata;
  assign spread_code_o = state_reg.code;
  assign mode_o = state_reg.mode;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------

  sequence cfg_write_s;
    req_i.wr && req_i.addr == DRC_SPREADING_RATE_CONFIG_OFFS;
  endsequence

  sequence no_write_s;
    !(req_i.wr && req_i.addr == DRC_SPREADING_RATE_CONFIG_OFFS);
  endsequence

  sequence cfg_read_s;
    req_i.rd && req_i.addr == DRC_SPREADING_RATE_CONFIG_OFFS;
  endsequence

  sequence stray_write_s;
    req_i.wr && req_i.addr != DRC_SPREADING_RATE_CONFIG_OFFS;
  endsequence

  // ----------------------------------------------------------------
  // register path
  // ----------------------------------------------------------------
  // read shows stored bits
  read_back_a: assert property (
    cfg_read_s |=> rdata_o == {5'h00, $past(state_reg.cfg)})
    else $error("read data does not show the stored bits");

  stray_write_a: assert property (
    stray_write_s |=> state_reg.cfg == $past(state_reg.cfg))
    else $error("write to another address changed the register");

  mode_hold_a: assert property (
    no_write_s |=> mode_o.code_width_32 == $past(mode_o.code_width_32) &&
      mode_o.double_rate == $past(mode_o.double_rate) &&
      mode_o.sample_12x == $past(mode_o.sample_12x))
    else $error("mode changed without a write");

  // ----------------------------------------------------------------
  // mode decode and code path
  // ----------------------------------------------------------------

  width_select_a: assert property (
    cfg_write_s |=> mode_o.code_width_32 == $past(req_i.wdata[2]) &&
      mode_o.chips_per_code == ($past(req_i.wdata[2]) ? DRC_CHIPS_32 : DRC_CHIPS_64))
    else $error("code width does not follow written bit 2");

  rate_mode_a: assert property (
    cfg_write_s ##1 no_write_s |=> mode_o.bits_per_code ==
      ($past(req_i.wdata[2], 2) && $past(req_i.wdata[1], 2) ? DRC_BITS_PER_CODE_DOUBLE
                                                            : DRC_BITS_PER_CODE_NORMAL))
    else $error("bits per code wrong after write");

  double_gated_a: assert property (
    mode_o.double_rate |-> mode_o.code_width_32)
    else $error("double rate active at 64-chip width");

  double_stored_a: assert property (
    mode_o.double_rate == (state_reg.cfg[DRC_CODE_WIDTH_BIT] &&
      state_reg.cfg[DRC_RATE_MODE_BIT]))
    else $error("double rate does not follow the stored bits");

  double_split_a: assert property (
    mode_o.double_rate |-> mode_o.raw_rate_bps == DRC_RAW_RATE_DOUBLE_BPS &&
      spread_code_o == $past(pn_code_i))
    else $error("double rate code or throughput wrong");

  normal_rate_a: assert property (
    !mode_o.double_rate |-> mode_o.raw_rate_bps == DRC_RAW_RATE_NORMAL_BPS)
    else $error("normal rate throughput wrong");

  sample_select_a: assert property (
    cfg_write_s |=> mode_o.oversample == (($past(req_i.wdata[2:0]) == 3'h5) ?
      DRC_OVERSAMPLE_12X : DRC_OVERSAMPLE_6X))
    else $error("oversampling choice wrong");

  half_select_a: assert property (
    mode_o.code_width_32 && !mode_o.double_rate |-> spread_code_o[31:0] ==
      ($past(code_half_select_i) ? $past(pn_code_i[63:32]) : $past(pn_code_i[31:0])) &&
      spread_code_o[63:32] == 32'h0000_0000)
    else $error("half select picked wrong chips");

  // full code at 64 chips
  // the code register lags reset by one cycle, so that edge is left out
  full_code_a: assert property (
    !mode_o.code_width_32 && !$past(reset_i) |-> spread_code_o == $past(pn_code_i) &&
      !mode_o.use_upper_half && !mode_o.double_rate)
    else $error("64-chip mode not using full code");

  reset_clear_a: assert property (@(posedge clk_i) disable iff (1'b0)
    reset_i |=> state_reg.cfg == 3'h0 && mode_o.oversample == DRC_OVERSAMPLE_6X &&
      !mode_o.code_width_32)
    else $error("reset did not clear configuration");

  invalid_flag_a: assert property (
    cfg_write_s |=> mode_o.config_invalid == ($past(req_i.wdata[2:0]) inside {3'h1, 3'h2,
      3'h3, 3'h7}))
    else $error("invalid pattern flag wrong");

endmodule : drc_rate_config

`default_nettype wire

// ==== drc_rate_config_test.sv ====
// self-checking bench for the spreading rate configuration block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module drc_rate_config_test;
  import drc_pkg::*;
  logic clk_i, reset_i, half;
  logic [63:0] pn;
  drc_req_t req;
  logic [7:0] rdata;
  logic [63:0] spread;
  drc_mode_t mode;
  int n_fail = 0;
  int check_count = 0;
  drc_rate_config drc_rate_config_inst (.clk_i(clk_i), .reset_i(reset_i), .req_i(req),
    .code_half_select_i(half), .pn_code_i(pn), .rdata_o(rdata), .spread_code_o(spread),
    .mode_o(mode));
  drc_host_model drc_host_model_inst (.clk_i(clk_i), .req_o(req));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    drc_host_model_inst.access(1'b1, a, d);
    settle();
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    drc_host_model_inst.access(1'b0, a, 8'h00);
    settle();
    `CHK("rdata", e, rdata)
  endtask : rd
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    settle();
    `CHK("chips", 7'h40, mode.chips_per_code)
    `CHK("oversample", 4'h6, mode.oversample)
    `CHK("rate", 16'h7D00, mode.raw_rate_bps)
    `CHK("spread", pn, spread)
    rd(6'h04, 8'h00);
  endtask : t_reset
  // every valid pattern the host may write, upper bits offered as ones, which the host model clears to zero
  task automatic t_modes();
    logic [2:0] c;
    logic d, s;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      if (c inside {DRC_BAD_PATTERN_A, DRC_BAD_PATTERN_B, DRC_BAD_PATTERN_C,
                    DRC_BAD_PATTERN_D}) continue;
      d = c[2] & c[1];
      s = c[2] & !c[1] & c[0];
      wr(6'h04, {5'h1F, c});
      `CHK("width", c[2], mode.code_width_32)
      `CHK("chips", c[2] ? 7'h20 : 7'h40, mode.chips_per_code)
      `CHK("double", d, mode.double_rate)
      `CHK("bits", d ? 2'h2 : 2'h1, mode.bits_per_code)
      `CHK("rate", d ? 16'hF424 : 16'h7D00, mode.raw_rate_bps)
      `CHK("s12", s, mode.sample_12x)
      `CHK("oversample", s ? 4'hC : 4'h6, mode.oversample)
      `CHK("invalid", 1'b0, mode.config_invalid)
      rd(6'h04, {5'h00, c});
    end
  endtask : t_modes
  task automatic t_half();
    wr(6'h04, 8'h04);
    @(posedge clk_i) half <= 1'b1;
    settle();
    `CHK("upper", ({32'h0, pn[63:32]}), spread)
    `CHK("use_upper", 1'b1, mode.use_upper_half)
    @(posedge clk_i) half <= 1'b0;
    settle();
    `CHK("lower", ({32'h0, pn[31:0]}), spread)
    @(posedge clk_i) half <= 1'b1;
    wr(6'h04, 8'h06);
    `CHK("dbl_code", pn, spread)
    `CHK("dbl_half", 1'b0, mode.use_upper_half)
    wr(6'h04, 8'h00);
    `CHK("full_code", pn, spread)
    wr(6'h05, 8'h07);
    rd(6'h04, 8'h00);
    rd(6'h05, 8'h00);
  endtask : t_half
  // a reset in mid-run brings the defaults back whatever was written
  task automatic t_rerun();
    wr(6'h04, 8'h05);
    `CHK("pre_s12", 1'b1, mode.sample_12x)
    @(posedge clk_i) reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    settle();
    `CHK("rst_chips", 7'h40, mode.chips_per_code)
    `CHK("rst_oversample", 4'h6, mode.oversample)
    `CHK("rst_s12", 1'b0, mode.sample_12x)
    `CHK("rst_spread", pn, spread)
    rd(6'h04, 8'h00);
  endtask : t_rerun
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    reset_i = 1'b1;
    half = 1'b0;
    pn = 64'hA5C30F1E9B724D68;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_modes();
    t_half();
    t_rerun();
    results();
  end
  // bound well above the roughly 90 cycles the scenarios need
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    results();
  end
endmodule : drc_rate_config_test
`default_nettype wire
